// >>> design/sbsi_defs.vh
/*
  constants for the spi buffer status and interrupt-select block:
  register offsets, status field positions, interrupt-select codes,
  fifo geometry.
  assumes an axi4-lite master on aclk and a link clock sampled as data.
*/
`ifndef SBSI_DEFS_VH
`define SBSI_DEFS_VH

`define SBSI_ADDR_W 8
`define SBSI_OFF_STAT 8'h00
`define SBSI_OFF_CTRL 8'h04
`define SBSI_OFF_DATA 8'h08
`define SBSI_OFF_IRQ_STAT 8'h0C
`define SBSI_OFF_IRQ_MASK 8'h10

`define SBSI_STAT_RBF 0
`define SBSI_STAT_TBF 1
`define SBSI_ISEL_LO 2
`define SBSI_ISEL_HI 4
`define SBSI_STAT_RFE 5
`define SBSI_STAT_ROV 6
`define SBSI_STAT_SRE 7
`define SBSI_CNT_LO 8
`define SBSI_CNT_HI 10

`define SBSI_CTRL_EN 0
`define SBSI_CTRL_ENH 1

`define SBSI_ISEL_RDLAST 3'b000
`define SBSI_ISEL_RAVAIL 3'b001
`define SBSI_ISEL_R34 3'b010
`define SBSI_ISEL_RFULL 3'b011
`define SBSI_ISEL_TWORD 3'b100
`define SBSI_ISEL_TDONE 3'b101
`define SBSI_ISEL_TEMPTY 3'b110

`define SBSI_DEPTH 4
`define SBSI_PTR_W 2
`define SBSI_CNT_W 3
`define SBSI_R34 3'h3
`define SBSI_FULL 3'h4
`define SBSI_WORD_W 16
`define SBSI_BIT_CNT_W 4
`define SBSI_LAST_BIT 4'hF

`define SBSI_RESP_OK 2'b00
`define SBSI_RESP_ERR 2'b10
`endif

// >>> design/sbsi_sync.v
/*
  three-stage synchroniser with edge detect; a change counts when
  stages two and three agree on a new value.
  assumes the input is asynchronous to aclk.
*/
`default_nettype none
module sbsi_sync
(
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire din,
  output reg level,
  output reg rise,
  output reg fall
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else if (ce)
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2 == s3 && s3 != level)
      begin
        level <= s3;
        rise <= s3;
        fall <= ~s3;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/sbsi_top.v
/*
  spi buffer status and interrupt select: tx/rx holding buffers or
  four-entry fifos, a 16-bit slave-style shifter, status flags, an
  event selector feeding a sticky status / mask interrupt, and an
  axi4-lite register slave.
  assumes sclk/ss_n/mosi are external pins of a spi master; mode 0.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
`include "sbsi_defs.vh"
module sbsi_top
(
  input wire aclk,
  input wire aresetn,
  input wire aclk_en,
  input wire [`SBSI_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SBSI_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire spi_sclk,
  input wire spi_ss_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg irq
);
  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  wire sclk_rise;
  wire sclk_fall;
  wire ss_n_lvl;
  wire mosi_lvl;
  sbsi_sync u_sclk
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(aclk_en),
    .din(spi_sclk),
    .level(),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );
  sbsi_sync u_ss
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(aclk_en),
    .din(spi_ss_n),
    .level(ss_n_lvl),
    .rise(),
    .fall()
  );
  sbsi_sync u_mosi
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(aclk_en),
    .din(spi_mosi),
    .level(mosi_lvl),
    .rise(),
    .fall()
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg module_enable_bit;
  reg enh_mode;
  reg [2:0] isel;
  reg rx_overflow_flag;
  reg [`SBSI_WORD_W-1:0] tx_fifo [0:`SBSI_DEPTH-1];
  reg [`SBSI_WORD_W-1:0] rx_fifo [0:`SBSI_DEPTH-1];
  reg [`SBSI_PTR_W-1:0] tx_wp;
  reg [`SBSI_PTR_W-1:0] tx_rp;
  reg [`SBSI_CNT_W-1:0] tx_cnt;
  reg [`SBSI_PTR_W-1:0] rx_wp;
  reg [`SBSI_PTR_W-1:0] rx_rp;
  reg [`SBSI_CNT_W-1:0] rx_cnt;
  reg [`SBSI_WORD_W-1:0] serial_shift_register;
  reg [`SBSI_WORD_W-1:0] rx_shift;
  reg [`SBSI_BIT_CNT_W-1:0] bit_cnt;
  reg sr_loaded;
  reg [6:0] irq_stat;
  reg [6:0] irq_mask;
  reg prev_sel_lvl;

  // ----------------------------------------------------------------
  // fifo limits per mode
  // ----------------------------------------------------------------
  wire [`SBSI_CNT_W-1:0] cap;
  assign cap = enh_mode ? `SBSI_FULL : 3'h1;
  wire tx_buffer_full_flag;
  wire rx_buffer_full_flag;
  wire rx_fifo_empty;
  wire shift_reg_empty_flag;
  assign tx_buffer_full_flag = (tx_cnt == cap);
  assign rx_buffer_full_flag = (rx_cnt == cap);
  assign rx_fifo_empty = enh_mode && (rx_cnt == 3'h0);
  assign shift_reg_empty_flag = ~sr_loaded;

  // ----------------------------------------------------------------
  // axi4-lite handshake
  // ----------------------------------------------------------------
  reg aw_held;
  reg w_held;
  reg [`SBSI_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_fire;
  wire rd_fire;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  wire data_wr;
  wire data_rd;
  assign data_wr = wr_fire && aw_addr == `SBSI_OFF_DATA
                   && w_strb[0] && module_enable_bit;
  assign data_rd = rd_fire && s_axi_araddr == `SBSI_OFF_DATA;
  wire rd_pop;
  assign rd_pop = data_rd && rx_cnt != 3'h0;
  wire tx_push;
  assign tx_push = data_wr && !tx_buffer_full_flag;

  // ----------------------------------------------------------------
  // shift engine events
  // ----------------------------------------------------------------
  wire active;
  assign active = module_enable_bit && !ss_n_lvl;
  wire load_sr;
  assign load_sr = module_enable_bit && !sr_loaded && tx_cnt != 3'h0;
  wire last_in;
  assign last_in = active && sclk_rise && bit_cnt == `SBSI_LAST_BIT;
  wire last_out;
  assign last_out = active && sclk_fall && bit_cnt == 4'h0 && sr_loaded
                    && !sclk_rise;
  wire rx_push;
  assign rx_push = last_in && (!rx_buffer_full_flag || rd_pop);
  wire rx_drop;
  assign rx_drop = last_in && rx_buffer_full_flag && !rd_pop;

  wire [`SBSI_CNT_W-1:0] next_tx_cnt;
  wire [`SBSI_CNT_W-1:0] next_rx_cnt;
  assign next_tx_cnt = tx_cnt + {2'b00, tx_push} - {2'b00, load_sr};
  assign next_rx_cnt = rx_cnt + {2'b00, rx_push} - {2'b00, rd_pop};

  // ----------------------------------------------------------------
  // interrupt source select
  // ----------------------------------------------------------------
  reg sel_lvl;
  reg sel_pulse;
  always @*
  begin
    sel_lvl = 1'b0;
    sel_pulse = 1'b0;
    case (isel)
      `SBSI_ISEL_TEMPTY: sel_pulse = last_in && tx_cnt == 3'h0;
      `SBSI_ISEL_TDONE: sel_pulse = last_out;
      `SBSI_ISEL_R34: sel_lvl = rx_cnt >= `SBSI_R34;
      `SBSI_ISEL_TWORD: sel_pulse = load_sr;
      `SBSI_ISEL_RFULL: sel_lvl = rx_buffer_full_flag;
      `SBSI_ISEL_RAVAIL: sel_lvl = rx_cnt != 3'h0;
      `SBSI_ISEL_RDLAST: sel_pulse = rd_pop && rx_cnt == 3'h1;
      default: sel_lvl = 1'b0;
    endcase
  end
  wire [6:0] events;
  assign events = {1'b0, rx_drop, last_out, load_sr, rx_push,
                   sel_pulse | (sel_lvl & !prev_sel_lvl), 1'b0};

  // ----------------------------------------------------------------
  // main sequential logic
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBSI_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SBSI_RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      module_enable_bit <= 1'b0;
      enh_mode <= 1'b0;
      isel <= 3'b000;
      rx_overflow_flag <= 1'b0;
      tx_wp <= 2'b00;
      tx_rp <= 2'b00;
      tx_cnt <= 3'h0;
      rx_wp <= 2'b00;
      rx_rp <= 2'b00;
      rx_cnt <= 3'h0;
      serial_shift_register <= 16'h0000;
      rx_shift <= 16'h0000;
      bit_cnt <= 4'h0;
      sr_loaded <= 1'b0;
      spi_miso <= 1'b0;
      irq_stat <= 7'h00;
      irq_mask <= 7'h00;
      irq <= 1'b0;
      prev_sel_lvl <= 1'b0;
    end
    else if (aclk_en)
    begin
      // axi write path
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SBSI_RESP_OK;
        if (aw_addr == `SBSI_OFF_STAT)
        begin
          if (w_strb[0])
            isel <= w_data[`SBSI_ISEL_HI:`SBSI_ISEL_LO];
          if (w_strb[0] && !w_data[`SBSI_STAT_ROV])
            rx_overflow_flag <= 1'b0;
        end
        else if (aw_addr == `SBSI_OFF_CTRL)
        begin
          if (w_strb[0])
          begin
            module_enable_bit <= w_data[`SBSI_CTRL_EN];
            enh_mode <= w_data[`SBSI_CTRL_ENH];
          end
        end
        else if (aw_addr == `SBSI_OFF_IRQ_MASK)
        begin
          if (w_strb[0])
            irq_mask <= w_data[6:0];
        end
        else if (aw_addr != `SBSI_OFF_DATA
                 && aw_addr != `SBSI_OFF_IRQ_STAT)
          s_axi_bresp <= `SBSI_RESP_ERR;
      end
      // axi read path
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SBSI_RESP_OK;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr == `SBSI_OFF_STAT)
        begin
          s_axi_rdata[`SBSI_STAT_RBF] <= rx_buffer_full_flag;
          s_axi_rdata[`SBSI_STAT_TBF] <= tx_buffer_full_flag;
          s_axi_rdata[`SBSI_ISEL_HI:`SBSI_ISEL_LO] <= isel;
          s_axi_rdata[`SBSI_STAT_RFE] <= rx_fifo_empty;
          s_axi_rdata[`SBSI_STAT_ROV] <= rx_overflow_flag;
          s_axi_rdata[`SBSI_STAT_SRE] <= shift_reg_empty_flag;
          s_axi_rdata[`SBSI_CNT_HI:`SBSI_CNT_LO] <= enh_mode ?
            rx_cnt : 3'h0;
        end
        else if (s_axi_araddr == `SBSI_OFF_CTRL)
        begin
          s_axi_rdata[`SBSI_CTRL_EN] <= module_enable_bit;
          s_axi_rdata[`SBSI_CTRL_ENH] <= enh_mode;
        end
        else if (s_axi_araddr == `SBSI_OFF_DATA)
        begin
          if (rx_cnt != 3'h0)
            s_axi_rdata[15:0] <= rx_fifo[rx_rp];
        end
        else if (s_axi_araddr == `SBSI_OFF_IRQ_STAT)
          s_axi_rdata[6:0] <= irq_stat;
        else if (s_axi_araddr == `SBSI_OFF_IRQ_MASK)
          s_axi_rdata[6:0] <= irq_mask;
        else
          s_axi_rresp <= `SBSI_RESP_ERR;
      end
      // transmit side
      if (tx_push)
      begin
        tx_fifo[tx_wp] <= w_data[15:0];
        tx_wp <= tx_wp + 2'b01;
      end
      if (load_sr)
      begin
        serial_shift_register <= tx_fifo[tx_rp];
        tx_rp <= tx_rp + 2'b01;
        sr_loaded <= 1'b1;
      end
      tx_cnt <= next_tx_cnt;
      // shifter, mode 0: sample on rise, shift out on fall
      if (!active)
        bit_cnt <= 4'h0;
      else if (sclk_rise)
      begin
        rx_shift <= {rx_shift[14:0], mosi_lvl};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (sclk_fall && sr_loaded)
      begin
        serial_shift_register <= {serial_shift_register[14:0], 1'b0};
        if (bit_cnt == 4'h0)
          sr_loaded <= 1'b0;
      end
      spi_miso <= serial_shift_register[15];
      // receive side
      if (rx_push)
      begin
        rx_fifo[rx_wp] <= {rx_shift[14:0], mosi_lvl};
        rx_wp <= rx_wp + 2'b01;
      end
      if (rx_drop)
        rx_overflow_flag <= 1'b1;
      if (rd_pop)
        rx_rp <= rx_rp + 2'b01;
      rx_cnt <= next_rx_cnt;
      if (!module_enable_bit)
      begin
        tx_wp <= 2'b00;
        tx_rp <= 2'b00;
        tx_cnt <= 3'h0;
        rx_wp <= 2'b00;
        rx_rp <= 2'b00;
        rx_cnt <= 3'h0;
        sr_loaded <= 1'b0;
      end
      // sticky interrupt status, read clears, set wins
      prev_sel_lvl <= sel_lvl;
      if (rd_fire && s_axi_araddr == `SBSI_OFF_IRQ_STAT)
        irq_stat <= events;
      else
        irq_stat <= irq_stat | events;
      irq <= |((irq_stat | events) & irq_mask);
    end
  end
endmodule
`default_nettype wire

// >>> verification/sbsi_spi_master.sv
/*
  spi master model for the buffer status block: mode 0, 16-bit words,
  msb first; clock runs only inside a frame.
  assumes the testbench calls frame and that the slave drives miso.
*/
`default_nettype none
module sbsi_spi_master
(
  output var logic sclk,
  output var logic ss_n,
  output var logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // -----------------------------------------------------------------
  // one frame; start phase offset from the system clock
  // -----------------------------------------------------------------
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    #1.3;
    ss_n = 1'b0;
    #32;
    for (int i = 15; i >= 0; i--)
    begin
      mosi = tx[i];
      #32 sclk = 1'b1;
      rx[i] = miso;
      #32 sclk = 1'b0;
    end
    #32 ss_n = 1'b1;
    // released line must not show the last bit
    mosi = ~tx[0];
  endtask
endmodule
`default_nettype wire

// >>> verification/sbsi_chk_chk.sv
/*
  checker for the register bus and reset behaviour of sbsi_top.
  assumes it is bound to sbsi_top and sees only its ports.
*/
`default_nettype none
`include "sbsi_defs.vh"
module sbsi_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SBSI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [`SBSI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  a_wr_unmapped: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready && s_axi_awaddr >= 8'h20
    |-> ##[1:2] s_axi_bvalid && s_axi_bresp == `SBSI_RESP_ERR)
    else $error("unmapped write not refused");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr >= 8'h20
    |-> ##[1:2] s_axi_rvalid && s_axi_rresp == `SBSI_RESP_ERR)
    else $error("unmapped read not refused");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped before rready");
  a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn
    |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs active in reset");
endmodule

bind sbsi_top sbsi_chk u_sbsi_chk
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);
`default_nettype wire

// >>> verification/tb_sbsi_top.sv
/*
  testbench for sbsi_top: axi4-lite register tasks, spi master model.
  assumes the register map of sbsi_defs.vh.
*/
`default_nettype none
`include "sbsi_defs.vh"
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_sbsi_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0, aresetn = 1'b0, aclk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, spi_sclk, spi_ss_n, spi_mosi, spi_miso, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  logic [31:0] rv;
  logic [1:0] rr, br;
  logic [15:0] mrx;
  int n_errors = 0, compares = 0;

  always #2 aclk = ~aclk;

  sbsi_top u_sbsi_top (.aclk, .aresetn, .aclk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso, .irq);
  sbsi_spi_master u_sbsi_spi_master (.sclk(spi_sclk), .ss_n(spi_ss_n),
    .mosi(spi_mosi), .miso(spi_miso));

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 200);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) n_errors++;
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 200);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) n_errors++;
  endtask

  task automatic xfer(input logic [15:0] t);
    u_sbsi_spi_master.frame(t, mrx);
    repeat (20) @(posedge aclk);
  endtask

  task test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_errors++;
    test_done();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`SBSI_OFF_STAT);
    `CHK("flags after reset", 2'b00, rv[1:0]);
    axi_read(8'h20);
    `CHK("unmapped read", `SBSI_RESP_ERR, rr);
    axi_write(8'h20, 32'h0000_0001);
    `CHK("unmapped write", `SBSI_RESP_ERR, br);
    axi_write(`SBSI_OFF_IRQ_MASK, 32'h0000_0004);
    axi_write(`SBSI_OFF_CTRL, 32'h0000_0001);
    axi_write(`SBSI_OFF_DATA, 32'h0000_A5A5);
    axi_write(`SBSI_OFF_DATA, 32'h0000_3C3C);
    axi_read(`SBSI_OFF_STAT);
    `CHK("tx full std", 1'b1, rv[1]);
    `CHK("irq masked", 1'b0, irq);
    xfer(16'h1234);
    `CHK("word on miso", 16'hA5A5, mrx);
    `CHK("irq rx word", 1'b1, irq);
    axi_read(`SBSI_OFF_IRQ_STAT);
    `CHK("irq status rx", 1'b1, rv[2]);
    axi_read(`SBSI_OFF_STAT);
    `CHK("irq cleared", 1'b0, irq);
    `CHK("tx full moved", 1'b0, rv[1]);
    `CHK("rx full std", 1'b1, rv[0]);
    xfer(16'h5678);
    axi_read(`SBSI_OFF_STAT);
    `CHK("overflow", 1'b1, rv[6]);
    axi_read(`SBSI_OFF_DATA);
    `CHK("old word kept", 16'h1234, rv[15:0]);
    axi_read(`SBSI_OFF_STAT);
    `CHK("rx full read", 1'b0, rv[0]);
    axi_write(`SBSI_OFF_CTRL, 32'h0000_0003);
    axi_write(`SBSI_OFF_STAT, 32'h0000_0008);
    axi_write(`SBSI_OFF_IRQ_MASK, 32'h0000_0002);
    axi_read(`SBSI_OFF_IRQ_STAT);
    for (int i = 0; i < 5; i++)
      axi_write(`SBSI_OFF_DATA, 32'h0000_0100 + i);
    axi_read(`SBSI_OFF_STAT);
    `CHK("tx full enh", 1'b1, rv[1]);
    for (int i = 0; i < 4; i++)
    begin
      xfer(16'h0200 + 16'(i));
      `CHK("irq three quarters", i >= 2, irq);
      if (i == 0)
      begin
        axi_read(`SBSI_OFF_STAT);
        `CHK("tx entry free", 1'b0, rv[1]);
      end
    end
    axi_read(`SBSI_OFF_STAT);
    `CHK("rx full enh", 1'b1, rv[0]);
    `CHK("rx not empty", 1'b0, rv[5]);
    `CHK("rx count", 3'h4, rv[10:8]);
    axi_read(`SBSI_OFF_DATA);
    `CHK("first rx word", 16'h0200, rv[15:0]);
    axi_read(`SBSI_OFF_STAT);
    `CHK("rx entry free", 1'b0, rv[0]);
    repeat (3) axi_read(`SBSI_OFF_DATA);
    axi_read(`SBSI_OFF_STAT);
    `CHK("rx empty", 1'b1, rv[5]);
    // remaining interrupt-select codes
    axi_write(`SBSI_OFF_STAT, 32'h0000_0014);
    axi_read(`SBSI_OFF_IRQ_STAT);
    xfer(16'h0300);
    `CHK("isel tx done", 1'b1, irq);
    axi_write(`SBSI_OFF_STAT, 32'h0000_0018);
    axi_write(`SBSI_OFF_DATA, 32'h0000_0500);
    axi_read(`SBSI_OFF_IRQ_STAT);
    xfer(16'h0301);
    `CHK("isel tx empty", 1'b1, irq);
    axi_write(`SBSI_OFF_STAT, 32'h0000_0010);
    axi_read(`SBSI_OFF_IRQ_STAT);
    axi_write(`SBSI_OFF_DATA, 32'h0000_0600);
    axi_read(`SBSI_OFF_IRQ_STAT);
    `CHK("isel tx word", 1'b1, rv[1]);
    axi_write(`SBSI_OFF_STAT, 32'h0000_000C);
    axi_read(`SBSI_OFF_IRQ_STAT);
    xfer(16'h0302);
    `CHK("isel rx not full", 1'b0, irq);
    xfer(16'h0303);
    `CHK("isel rx full", 1'b1, irq);
    axi_write(`SBSI_OFF_STAT, 32'h0000_0000);
    axi_read(`SBSI_OFF_IRQ_STAT);
    repeat (3) axi_read(`SBSI_OFF_DATA);
    `CHK("isel not last", 1'b0, irq);
    axi_read(`SBSI_OFF_DATA);
    `CHK("last rx word", 16'h0303, rv[15:0]);
    `CHK("isel last read", 1'b1, irq);
    axi_write(`SBSI_OFF_STAT, 32'h0000_0004);
    axi_read(`SBSI_OFF_IRQ_STAT);
    xfer(16'h0304);
    `CHK("isel rx avail", 1'b1, irq);
    // frozen clock enable: a frame must leave no trace
    aclk_en <= 1'b0;
    xfer(16'h0305);
    aclk_en <= 1'b1;
    axi_read(`SBSI_OFF_STAT);
    `CHK("frozen rx count", 3'h1, rv[10:8]);
    test_done();
  end
endmodule
`default_nettype wire
